// >>> pkg/pie_consts.svh
`ifndef PIE_CONSTS_SVH
`define PIE_CONSTS_SVH
// Register byte offsets
`define PIE_OFF_ENABLE_TWO  12'h000
`define PIE_OFF_FLAGS       12'h004
`define PIE_OFF_GLOBAL      12'h008
`define PIE_OFF_IRQ_STATUS  12'h00C
`define PIE_OFF_IRQ_MASK    12'h010
`define PIE_OFF_IRQ_CLEAR   12'h014
// Reset values
`define PIE_RST_ENABLE_TWO  8'h00
`define PIE_RST_GLOBAL      1'b0
// Bit positions of the enable register
`define PIE_BIT_CCU_SIX     7
`define PIE_BIT_CCU_FIVE    6
`define PIE_BIT_CCU_FOUR    5
`define PIE_BIT_CCU_THREE   4
`define PIE_BIT_TMR_SIX     3
`define PIE_BIT_TMR_FIVE    2
`define PIE_BIT_TMR_FOUR    1
`define PIE_BIT_TMR_THREE   0
`endif

// >>> pkg/pie_pkg.sv
package pie_pkg;
    // Enable bits in register order, bit 7 first
    typedef struct packed {
        logic ccu_six_irq_en;
        logic ccu_five_irq_en;
        logic ccu_four_irq_en;
        logic ccu_three_irq_en;
        logic timer_six_match_irq_en;
        logic timer_five_overflow_irq_en;
        logic timer_four_match_irq_en;
        logic timer_three_overflow_irq_en;
    } pie_enable_t;

    // Registered AHB address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
    } pie_aphase_t;
endpackage

// >>> logic/pie_sync.sv
`timescale 1ns/1ns
// Three-stage input synchroniser; output changes when stages two and three agree
module pie_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             hclk,     // System clock
    input  wire logic             hresetn,  // Async reset, active low
    input  wire logic [WIDTH-1:0] d,        // Asynchronous input
    output logic      [WIDTH-1:0] q         // Filtered synchronous output
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    // Refuse a width the stages cannot serve
    if (WIDTH < 1)
    begin
        $error("pie_sync: WIDTH must be positive");
    end

    // Accept a bit only when the second and third stages agree
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
        end
    end

    // Stage registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// >>> logic/pie_bank_two.sv
// Design decisions made here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "pie_consts.svh"
// Functional notes
// - Unit six capture request passes only while enable bit 7 is one.
// - Unit five capture request passes only while enable bit 6 is one.
// - Bits 5 and 4 gate capture units four and three requests.
// - Bits 3 and 1 gate timer six and timer four period match events.
module pie_bank_two (
    input  wire logic        hclk,        // System clock, 250 MHz
    input  wire logic        hresetn,     // Async reset, active low
    input  wire logic        hsel,        // Slave select
    input  wire logic [31:0] haddr,       // Byte address
    input  wire logic [1:0]  htrans,      // Transfer type
    input  wire logic        hwrite,      // Write when high
    input  wire logic [2:0]  hsize,       // Transfer size
    input  wire logic        hready,      // Bus ready in
    input  wire logic [31:0] hwdata,      // Write data
    output logic      [31:0] hrdata,      // Read data
    output logic             hreadyout,   // Slave ready
    output logic             hresp,       // Response, always OKAY
    input  wire logic [7:0]  src_req,     // Peripheral request flags, async
    output logic      [7:0]  cpu_req,     // Gated requests to the core
    output logic             cpu_irq,     // Any gated request with global enable
    output logic             irq          // Block interrupt output
);
    localparam int NSRC = 8;

    pie_pkg::pie_enable_t en_r;
    pie_pkg::pie_enable_t en_nxt;
    pie_pkg::pie_aphase_t ap_r;
    pie_pkg::pie_aphase_t ap_nxt;
    logic              glb_r;
    logic              glb_nxt;
    logic [NSRC-1:0]   req_s;
    logic [NSRC-1:0]   cpu_req_r;
    logic [NSRC-1:0]   cpu_req_nxt;
    logic              cpu_irq_r;
    logic              cpu_irq_nxt;
    logic [NSRC-1:0]   prev_r;
    logic [NSRC-1:0]   sts_r;
    logic [NSRC-1:0]   sts_nxt;
    logic [NSRC-1:0]   msk_r;
    logic [NSRC-1:0]   msk_nxt;
    logic              irq_r;
    logic              irq_nxt;
    logic [31:0]       rd_r;
    logic [31:0]       rd_nxt;
    logic              wr_en;
    logic [NSRC-1:0]   clr;
    logic [NSRC-1:0]   rise;
    logic              hready_r;
    logic              hresp_r;

    // Refuse a source count that the enable layout cannot serve
    if (NSRC != $bits(pie_pkg::pie_enable_t))
    begin
        $error("pie_bank_two: width mismatch");
    end

    // Gate a request vector with the enable bits
    function automatic logic [NSRC-1:0] gate(input logic [NSRC-1:0] r,
                                             input logic [NSRC-1:0] e);
        gate = r & e;
    endfunction

    // Synchronise the external request flags
    pie_sync #(
        .WIDTH (NSRC)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (src_req),
        .q       (req_s)
    );

    // AHB address phase capture and data-phase write decode
    always_comb
    begin
        ap_nxt.valid = hsel && hready && htrans[1];
        ap_nxt.write = hwrite;
        ap_nxt.addr  = haddr[11:0];
        wr_en        = ap_r.valid && ap_r.write;
    end

    // Register writes
    always_comb
    begin
        en_nxt  = en_r;
        glb_nxt = glb_r;
        msk_nxt = msk_r;
        clr     = '0;
        if (wr_en)
        begin
            unique case (ap_r.addr)
                `PIE_OFF_ENABLE_TWO: en_nxt  = pie_pkg::pie_enable_t'(hwdata[7:0]);
                `PIE_OFF_GLOBAL:     glb_nxt = hwdata[0];
                `PIE_OFF_IRQ_MASK:   msk_nxt = hwdata[7:0];
                `PIE_OFF_IRQ_CLEAR:  clr     = hwdata[7:0];
                default:             ;
            endcase
        end
    end

    // Gating toward the core, one bit per source
    always_comb
    begin
        cpu_req_nxt = gate(req_s, en_r);
        cpu_irq_nxt = glb_r && (|cpu_req_nxt);
    end

    // Sticky status on rising gated requests; set wins over clear
    always_comb
    begin
        rise    = cpu_req_nxt & ~prev_r;
        sts_nxt = (sts_r & ~clr) | rise;
        irq_nxt = |(sts_nxt & msk_nxt);
    end

    // Read data for the next data phase
    always_comb
    begin
        rd_nxt = 32'h0000_0000;
        if (ap_nxt.valid && !hwrite)
        begin
            unique case (ap_nxt.addr)
                `PIE_OFF_ENABLE_TWO: rd_nxt = {24'h00_0000, en_r};
                `PIE_OFF_FLAGS:      rd_nxt = {24'h00_0000, req_s};
                `PIE_OFF_GLOBAL:     rd_nxt = {31'h0000_0000, glb_r};
                `PIE_OFF_IRQ_STATUS: rd_nxt = {24'h00_0000, sts_r};
                `PIE_OFF_IRQ_MASK:   rd_nxt = {24'h00_0000, msk_r};
                default:             rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // State registers, all cleared on reset except hready_r, which resets to one
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en_r      <= pie_pkg::pie_enable_t'(`PIE_RST_ENABLE_TWO);
            glb_r     <= `PIE_RST_GLOBAL;
            ap_r      <= '0;
            cpu_req_r <= '0;
            cpu_irq_r <= 1'b0;
            prev_r    <= '0;
            sts_r     <= '0;
            msk_r     <= '0;
            irq_r     <= 1'b0;
            rd_r      <= 32'h0000_0000;
            hready_r  <= 1'b1;
            hresp_r   <= 1'b0;
        end
        else
        begin
            en_r      <= en_nxt;
            glb_r     <= glb_nxt;
            ap_r      <= ap_nxt;
            cpu_req_r <= cpu_req_nxt;
            cpu_irq_r <= cpu_irq_nxt;
            prev_r    <= cpu_req_nxt;
            sts_r     <= sts_nxt;
            msk_r     <= msk_nxt;
            irq_r     <= irq_nxt;
            rd_r      <= rd_nxt;
            hready_r  <= 1'b1;
            hresp_r   <= 1'b0;
        end
    end

    // Outputs straight from their registers; zero wait states, always OKAY
    assign hrdata    = rd_r;
    assign hreadyout = hready_r;
    assign hresp     = hresp_r;
    assign cpu_req   = cpu_req_r;
    assign cpu_irq   = cpu_irq_r;
    assign irq       = irq_r;

    // Gating, enable write and reset checks
    a_ccu_six_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        !en_r.ccu_six_irq_en |=> !cpu_req[7])
        else $error("unit six request passed while masked");
    a_ccu_six_pass: assert property (@(posedge hclk) disable iff (!hresetn)
        (en_r.ccu_six_irq_en && req_s[7]) |=> cpu_req[7])
        else $error("unit six request not forwarded");
    a_ccu_five_pass: assert property (@(posedge hclk) disable iff (!hresetn)
        (en_r.ccu_five_irq_en && req_s[6]) |=> cpu_req[6])
        else $error("unit five request not forwarded");
    a_ccu_low_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 (cpu_req[5:4] == ($past(req_s[5:4]) & $past(en_r[5:4]))))
        else $error("units four/three gating wrong");
    a_tmr_match_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 ({cpu_req[3], cpu_req[1]} ==
             ({$past(req_s[3]), $past(req_s[1])} & {$past(en_r[3]), $past(en_r[1])})))
        else $error("timer match gating wrong");
    a_tmr_ovf_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 ({cpu_req[2], cpu_req[0]} ==
             ({$past(req_s[2]), $past(req_s[0])} & {$past(en_r[2]), $past(en_r[0])})))
        else $error("timer overflow gating wrong");
    a_global_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        !glb_r |=> !cpu_irq)
        else $error("core interrupt without global enable");
    a_global_pass: assert property (@(posedge hclk) disable iff (!hresetn)
        (glb_r && (|cpu_req_nxt)) |=> cpu_irq)
        else $error("core interrupt missing with global enable");
    a_enable_write: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_en && ap_r.addr == `PIE_OFF_ENABLE_TWO) |=> (en_r == $past(hwdata[7:0])))
        else $error("enable write not stored");
    a_reset_clear: assert property (@(posedge hclk)
        !hresetn |-> (en_r == '0 && cpu_req == '0 && !cpu_irq && !irq))
        else $error("state not cleared in reset");

    // Status and bus checks
    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 (irq == |($past(sts_nxt) & $past(msk_nxt))))
        else $error("interrupt output disagrees with status");
    a_status_set: assert property (@(posedge hclk) disable iff (!hresetn)
        (|rise) |=> ((sts_r & $past(rise)) == $past(rise)))
        else $error("status bit missed a rising request");
    a_read_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        (!ap_nxt.valid || ap_nxt.write) |=> (hrdata == 32'h0000_0000))
        else $error("read data outside a read data phase");
endmodule

// >>> sim/pie_src_model.sv
`timescale 1ns/1ns
// Peripheral request sources: levels move just after a clock edge, quiet in reset
module pie_src_model (
    input  wire logic       hclk,     // System clock
    input  wire logic       hresetn,  // Async reset, active low
    input  wire logic [7:0] pattern,  // Levels commanded by the bench
    output logic      [7:0] src_req   // Request flags into the block
);
    // Register the commanded levels
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            src_req <= 8'h00;
        else
            src_req <= pattern;
    end
endmodule

// >>> sim/pie_bank_two_tb.sv
`timescale 1ns/1ns
`include "pie_consts.svh"
module pie_bank_two_tb;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cpu_irq, irq;
    logic [1:0]  htrans;
    logic [7:0]  pattern, src_req, cpu_req;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          n_fail, checks;

    pie_src_model SRC (.hclk(hclk), .hresetn(hresetn), .pattern(pattern), .src_req(src_req));
    pie_bank_two DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req),
        .cpu_req(cpu_req), .cpu_irq(cpu_irq), .irq(irq));

    // Report counts and end the run
    task automatic print_verdict();
    begin
        $display("Checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask

    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // Wait for an edge with hready high, bounded
    task automatic wait_ready();
        int n;
    begin
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                n_fail++;
                print_verdict();
            end
            @(posedge hclk);
        end
    end
    endtask

    // One AHB-Lite single word transfer
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    begin
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    end
    endtask

    // Read a register and compare
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    begin
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    end
    endtask

    // Let requests cross the synchroniser and output register
    task automatic settle();
    begin
        repeat (8) @(posedge hclk);
    end
    endtask

    // Free-running clock
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // Watchdog against a hang
    initial
    begin
        #400000;
        n_fail++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        pattern = 8'h00;
        n_fail = 0;
        checks = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(`PIE_OFF_ENABLE_TWO, 32'h0);
        rchk(`PIE_OFF_GLOBAL, 32'h0);
        xfer(1'b1, `PIE_OFF_ENABLE_TWO, 32'h000000A5);
        rchk(`PIE_OFF_ENABLE_TWO, 32'h000000A5);
        xfer(1'b1, `PIE_OFF_ENABLE_TWO, 32'h0000005A);
        rchk(`PIE_OFF_ENABLE_TWO, 32'h0000005A);
        rchk(12'h020, 32'h0);
        xfer(1'b1, 12'h020, 32'h000000FF);
        rchk(`PIE_OFF_ENABLE_TWO, 32'h0000005A);
        // Each enable passes its own source only; global off keeps the core quiet
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b1, `PIE_OFF_ENABLE_TWO, 32'h1 << i);
            pattern <= 8'hFF;
            settle();
            chk({24'h0, cpu_req}, 32'h1 << i);
            chk({31'h0, cpu_irq}, 32'h0);
            pattern <= ~(8'h01 << i);
            settle();
            chk({24'h0, cpu_req}, 32'h0);
        end
        // Software sets the global enable before the core is interrupted
        xfer(1'b1, `PIE_OFF_GLOBAL, 32'h1);
        pattern <= 8'h80;
        settle();
        chk({31'h0, cpu_irq}, 32'h1);
        rchk(`PIE_OFF_FLAGS, 32'h80);
        xfer(1'b1, `PIE_OFF_GLOBAL, 32'h0);
        settle();
        chk({31'h0, cpu_irq}, 32'h0);
        // Sticky status, mask and clear
        rchk(`PIE_OFF_IRQ_STATUS, 32'hFF);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, `PIE_OFF_IRQ_MASK, 32'h80);
        settle();
        chk({31'h0, irq}, 32'h1);
        pattern <= 8'h00;
        settle();
        xfer(1'b1, `PIE_OFF_IRQ_CLEAR, 32'hFF);
        rchk(`PIE_OFF_IRQ_STATUS, 32'h0);
        settle();
        chk({31'h0, irq}, 32'h0);
        pattern <= 8'h80;
        settle();
        rchk(`PIE_OFF_IRQ_STATUS, 32'h80);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, `PIE_OFF_IRQ_MASK, 32'h0);
        settle();
        chk({31'h0, irq}, 32'h0);
        // Reset in mid-run clears every enable
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(`PIE_OFF_ENABLE_TWO, 32'h0);
        chk({24'h0, cpu_req}, 32'h0);
        print_verdict();
    end
endmodule
